// ===== rtl/fvs_slave.sv
module fvs_slave
  import fvs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration switches
  input  wire logic [7:0] config_switch,
  // Network status from protocol engine
  input  wire logic       reset_msg,
  input  wire logic       conn_open,
  input  wire logic       conn_timeout,
  input  wire logic       bus_critical,
  // Cyclic I/O
  input  wire logic       poll_req,
  input  wire logic       strobe_req,
  input  wire logic       cos_enable,
  input  wire logic       io_out_valid,
  input  wire logic [7:0] io_out_data,
  output logic            io_in_valid,
  output logic [7:0]      io_in_data,
  // Explicit messaging
  input  fvs_pkg::fvs_svc_e exp_svc,
  input  wire logic [7:0] exp_class,
  input  wire logic [7:0] exp_inst,
  input  wire logic [7:0] exp_attr,
  input  wire logic [7:0] exp_wdata,
  output logic            exp_ack,
  output logic            exp_err,
  output logic [7:0]      exp_rdata,
  // Sensors
  input  wire logic       pos_bottom,
  input  wire logic       pos_top,
  // Valve and indicators
  output logic            pilot_valve_one,
  output logic            led_green,
  output logic            led_red,
  // Active configuration
  output logic [5:0]      node_address,
  output logic [1:0]      rate_code,
  output logic            rate_bad
);

  //------------------------------------------------------------------------
  // Configuration capture
  //------------------------------------------------------------------------
  fvs_cfg_latch u_cfg (
    .clk          (clk),
    .rst          (rst),
    .restart_req  (reset_msg),
    .config_switch(config_switch),
    .node_address (node_address),
    .rate_code    (rate_code),
    .rate_bad     (rate_bad)
  );

  //------------------------------------------------------------------------
  // Bus state and indicator
  //------------------------------------------------------------------------
  fvs_bus_e bus_state;
  wire      bus_fault = conn_timeout || bus_critical || !conn_open;

  assign bus_state = bus_critical ? FVS_BUS_CRIT :
                     conn_timeout ? FVS_BUS_TIMEOUT :
                     !conn_open   ? FVS_BUS_NOCONN : FVS_BUS_OK;

  fvs_led u_led (
    .clk      (clk),
    .rst      (rst),
    .bus_state(bus_state),
    .led_green(led_green),
    .led_red  (led_red)
  );

  //------------------------------------------------------------------------
  // Registers
  //------------------------------------------------------------------------
  logic [7:0] inputs_reg;
  logic       valve_cmd_reg;
  logic       safe_val_reg;
  logic       flt_mode_reg;
  logic       fault_d_reg;

  wire [7:0] inputs_next = {6'h00, pos_top, pos_bottom};

  // Explicit decode, open regardless of bus fault.
  wire is_proc = (exp_class == CLS_PROCESS) && (exp_inst == INST_ONE)
                 && (exp_attr == ATT_PROCESS);
  wire is_cfg  = (exp_class == CLS_CONFIG) && (exp_inst == INST_ONE);
  wire is_safe = is_cfg && (exp_attr == ATT_SAFE_VAL);
  wire is_mode = is_cfg && (exp_attr == ATT_FLT_MODE);
  wire is_get  = (exp_svc == FVS_SVC_GET);
  wire is_set  = (exp_svc == FVS_SVC_SET);
  wire hit     = is_proc || is_safe || is_mode;
  wire wr_proc = is_set && is_proc;
  wire wr_safe = is_set && is_safe;
  wire wr_mode = is_set && is_mode;

  // Only bit 0 is kept; upper bits are zero by contract of the master.
  wire cmd_next = wr_proc ? exp_wdata[0] :
                  (io_out_valid && !bus_fault) ? io_out_data[0] :
                  valve_cmd_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inputs_reg    <= '0;
      valve_cmd_reg <= 1'b0;
      safe_val_reg  <= SAFE_VAL_RST;
      flt_mode_reg  <= FLT_MODE_RST;
      fault_d_reg   <= 1'b0;
    end else if (reset_msg) begin
      inputs_reg    <= '0;
      valve_cmd_reg <= 1'b0;
      safe_val_reg  <= SAFE_VAL_RST;
      flt_mode_reg  <= FLT_MODE_RST;
      fault_d_reg   <= 1'b0;
    end else begin
      inputs_reg    <= inputs_next;
      valve_cmd_reg <= cmd_next;
      safe_val_reg  <= wr_safe ? exp_wdata[0] : safe_val_reg;
      flt_mode_reg  <= wr_mode ? exp_wdata[0] : flt_mode_reg;
      fault_d_reg   <= bus_fault;
    end
  end

  //------------------------------------------------------------------------
  // Valve drive under fault
  //------------------------------------------------------------------------
  // Hold mode keeps the last command; during the fault only an explicit Set or a reset message can change it.
  wire valve_next = (bus_fault && !flt_mode_reg) ? safe_val_reg
                                                 : valve_cmd_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pilot_valve_one <= 1'b0;
    end else begin
      pilot_valve_one <= valve_next;
    end
  end

  //------------------------------------------------------------------------
  // Cyclic input production
  //------------------------------------------------------------------------
  wire cos_hit  = cos_enable && (inputs_next != inputs_reg);
  wire send_now = poll_req || strobe_req || cos_hit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_in_valid <= 1'b0;
      io_in_data  <= '0;
    end else begin
      io_in_valid <= send_now && conn_open;
      io_in_data  <= send_now ? inputs_next : io_in_data;
    end
  end

  //------------------------------------------------------------------------
  // Explicit answer
  //------------------------------------------------------------------------
  wire [7:0] rd_mux = is_proc ? inputs_reg :
                      is_safe ? {7'h00, safe_val_reg} :
                      is_mode ? {7'h00, flt_mode_reg} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_ack   <= 1'b0;
      exp_err   <= 1'b0;
      exp_rdata <= '0;
    end else begin
      exp_ack   <= is_get || is_set;
      exp_err   <= (is_get || is_set) && !hit;
      exp_rdata <= (is_get && hit) ? rd_mux : 8'h00;
    end
  end

endmodule : fvs_slave

// ===== rtl/fvs_pkg.sv
//--------------------------------------------------------------------------
// Notes on behaviour
// - Node address from switches 1-6, binary.
// - Switches 7-8 select 125/250/500 kbaud rate.
// - Switch changes wait for next restart.
// - Power cycle or reset message restarts.
// - Polled, strobed cyclic; change-of-state sends inputs.
// - Class 4 attr 3: read inputs, write outputs.
// - Input bit0 bottom, bit1 top, rest zero.
// - Output bit0 drives pilot valve; others zero.
// - Bus fault shown as flash green/red or red.
// - Class 150 attr 7 bit0: safety or hold.
// - Class 150 attr 6 bit0: fault valve state.
// - Fault config accessible even during bus fault.
// - Bus failure forces safety setting, default off.
//--------------------------------------------------------------------------
package fvs_pkg;

  //------------------------------------------------------------------------
  // Object addressing
  //------------------------------------------------------------------------
  localparam logic [7:0] CLS_PROCESS  = 8'h04;
  localparam logic [7:0] CLS_CONFIG   = 8'h96;
  localparam logic [7:0] INST_ONE     = 8'h01;
  localparam logic [7:0] ATT_PROCESS  = 8'h03;
  localparam logic [7:0] ATT_SAFE_VAL = 8'h06;
  localparam logic [7:0] ATT_FLT_MODE = 8'h07;

  //------------------------------------------------------------------------
  // Switch fields and codes
  //------------------------------------------------------------------------
  localparam int         ADDR_LSB   = 0;
  localparam int         RATE_LSB   = 6;
  localparam logic [1:0] RATE_125   = 2'h0;
  localparam logic [1:0] RATE_250   = 2'h1;
  localparam logic [1:0] RATE_500   = 2'h2;
  localparam logic [1:0] RATE_BAD   = 2'h3;

  //------------------------------------------------------------------------
  // Reset values and indicator timing
  //------------------------------------------------------------------------
  localparam logic       SAFE_VAL_RST = 1'b0;
  localparam logic       FLT_MODE_RST = 1'b0;
  localparam int         CLK_HZ       = 25000000;
  localparam int         FLASH_MS     = 500;
  localparam int         FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;
  localparam int         FLASH_W      = 24;

  typedef enum logic [1:0] {
    FVS_SVC_NONE,
    FVS_SVC_GET,
    FVS_SVC_SET
  } fvs_svc_e;

  typedef enum logic [2:0] {
    FVS_BUS_OK,
    FVS_BUS_NOCONN,
    FVS_BUS_TIMEOUT,
    FVS_BUS_CRIT
  } fvs_bus_e;

endpackage : fvs_pkg

// ===== rtl/fvs_cfg_latch.sv
module fvs_cfg_latch
  import fvs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       restart_req,
  // Switches
  input  wire logic [7:0] config_switch,
  // Captured configuration
  output logic [5:0]      node_address,
  output logic [1:0]      rate_code,
  output logic            rate_bad
);

  //------------------------------------------------------------------------
  // Capture after reset release and on each restart request
  //------------------------------------------------------------------------
  // The capture is clocked because an async reset may only load constants.
  logic armed_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg    <= 1'b1;
      node_address <= '0;
      rate_code    <= RATE_125;
    end else if (armed_reg || restart_req) begin
      armed_reg    <= 1'b0;
      node_address <= config_switch[ADDR_LSB +: 6];
      rate_code    <= config_switch[RATE_LSB +: 2];
    end
  end

  // Held otherwise, so live switch moves are ignored.
  assign rate_bad = (rate_code == RATE_BAD);

endmodule : fvs_cfg_latch

// ===== rtl/fvs_led.sv
module fvs_led
  import fvs_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bus state
  input  fvs_pkg::fvs_bus_e bus_state,
  // Indicator drive
  output logic      led_green,
  output logic      led_red
);

  logic [FLASH_W-1:0] cnt_reg;
  logic               ph_reg;
  wire                wrap = (cnt_reg == FLASH_W'(FLASH_CYC - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      ph_reg  <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      ph_reg  <= wrap ? ~ph_reg : ph_reg;
    end
  end

  //------------------------------------------------------------------------
  // Colour selection
  //------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else begin
      unique case (bus_state)
        FVS_BUS_OK: begin
          led_green <= 1'b1;
          led_red   <= 1'b0;
        end
        FVS_BUS_NOCONN: begin
          led_green <= ph_reg;
          led_red   <= 1'b0;
        end
        FVS_BUS_TIMEOUT: begin
          led_green <= 1'b0;
          led_red   <= ph_reg;
        end
        default: begin
          led_green <= 1'b0;
          led_red   <= 1'b1;
        end
      endcase
    end
  end

endmodule : fvs_led

// ===== verif/fvs_slave_checker.sv
module fvs_slave_checker
  import fvs_pkg::*;
(
  input wire logic         clk, rst, reset_msg, conn_open, conn_timeout,
  input wire logic         bus_critical, poll_req, strobe_req,
  input wire logic [7:0]   config_switch, exp_class, exp_inst, exp_attr,
  input fvs_pkg::fvs_svc_e exp_svc,
  input wire logic         exp_ack, exp_err, io_in_valid, pilot_valve_one,
  input wire logic         led_green, led_red, rate_bad,
  input wire logic [7:0]   exp_rdata, io_in_data,
  input wire logic [5:0]   node_address,
  input wire logic [1:0]   rate_code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire fault = !conn_open || conn_timeout || bus_critical;
  sequence s_get_in;
    exp_svc == FVS_SVC_GET && exp_class == CLS_PROCESS &&
    exp_inst == INST_ONE && exp_attr == ATT_PROCESS;
  endsequence
  // Four quiet cycles let any fault onset or config write settle first.
  sequence s_fault_quiet;
    (fault && !reset_msg && exp_svc == FVS_SVC_NONE) [*4];
  endsequence
  a_get_input: assert property (s_get_in |=> exp_ack && !exp_err &&
    exp_rdata[7:2] == 6'h00) else $error("input read reply wrong");
  a_bad_class: assert property (exp_svc != FVS_SVC_NONE &&
    exp_class != CLS_PROCESS && exp_class != CLS_CONFIG
    |=> exp_ack && exp_err && exp_rdata == 8'h00) else $error("no refusal");
  a_idle_quiet: assert property (exp_svc == FVS_SVC_NONE |=>
    !exp_ack) else $error("reply without request");
  a_poll_answer: assert property ((poll_req || strobe_req) && !fault
    |=> io_in_valid && io_in_data[7:2] == 6'h00) else $error("no poll data");
  a_addr_capture: assert property ($past(rst) |=>
    {rate_code, node_address} == $past(config_switch))
    else $error("switches not captured");
  a_cfg_stable: assert property (!reset_msg && !$past(reset_msg) &&
    !$past(rst) |=> $stable({node_address, rate_code}))
    else $error("configuration moved");
  a_rate_flag: assert property (rate_bad == (rate_code == RATE_BAD))
    else $error("rate flag wrong");
  a_fault_hold: assert property (s_fault_quiet |=>
    $stable(pilot_valve_one)) else $error("valve moved in fault");
  a_critical_red: assert property (bus_critical [*2] |->
    led_red && !led_green) else $error("no steady red");
  a_fault_silent: assert property (!conn_open |=> !io_in_valid)
    else $error("cyclic data without connection");
endmodule : fvs_slave_checker

bind fvs_slave fvs_slave_checker i_chk (.clk, .rst, .reset_msg, .conn_open,
  .conn_timeout, .bus_critical, .poll_req, .strobe_req, .config_switch,
  .exp_class, .exp_inst, .exp_attr, .exp_svc, .exp_ack, .exp_err,
  .io_in_valid, .pilot_valve_one, .led_green, .led_red, .rate_bad,
  .exp_rdata, .io_in_data, .node_address, .rate_code);

// ===== verif/fvs_master_model.sv
module fvs_master_model (
  input wire logic   clk,
  input wire logic   send,
  input wire logic   valve,
  output logic       io_out_valid,
  output logic [7:0] io_out_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside a transfer the byte toggles so stale data cannot pass.
  always @(posedge clk) begin
    io_out_valid <= send;
    io_out_data  <= send ? {7'h00, valve} : ~io_out_data;
  end
  initial io_out_data = 8'h5a;
endmodule : fvs_master_model

// ===== verif/fvs_slave_tb.sv
module fvs_slave_tb;
  import fvs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, reset_msg, conn_open, conn_timeout, bus_critical, send;
  logic poll_req, strobe_req, cos_enable, io_out_valid, exp_ack, exp_err;
  logic io_in_valid, pos_bottom, pos_top, pilot_valve_one, led_green;
  logic led_red, rate_bad, valve;
  logic [7:0] config_switch, io_out_data, io_in_data, exp_class, exp_inst;
  logic [7:0] exp_attr, exp_wdata, exp_rdata, sw;
  logic [5:0] node_address;
  logic [1:0] rate_code;
  logic [9:0] e;
  fvs_svc_e   exp_svc;
  int         fail_count, checked, seed = 32'h17e5d85c;
  logic [9:0] qa[$];
  logic [7:0] qi[$];
  fvs_slave i_dut (.clk, .rst, .config_switch, .reset_msg, .conn_open,
    .conn_timeout, .bus_critical, .poll_req, .strobe_req, .cos_enable,
    .io_out_valid, .io_out_data, .io_in_valid, .io_in_data, .exp_svc,
    .exp_class, .exp_inst, .exp_attr, .exp_wdata, .exp_ack, .exp_err,
    .exp_rdata, .pos_bottom, .pos_top, .pilot_valve_one, .led_green,
    .led_red, .node_address, .rate_code, .rate_bad);
  fvs_master_model i_master (.clk, .send, .valve, .io_out_valid,
    .io_out_data);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(string n, logic [8:0] x, logic [8:0] s);
    checked++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic req(fvs_svc_e s, logic [7:0] c, logic [7:0] a,
                     logic [7:0] w, logic [9:0] x);
    qa.push_back(x);
    exp_svc = s;
    exp_class = c;
    exp_attr = a;
    exp_wdata = w;
    tick(1);
    exp_svc = FVS_SVC_NONE;
    tick(2);
  endtask : req
  task automatic write_valve(logic v);
    valve = v;
    send = 1'b1;
    tick(1);
    send = 1'b0;
    tick(3);
  endtask : write_valve
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // --------------------
  // Reply and cyclic input monitor
  // --------------------
  always @(posedge clk) begin
    if (exp_ack === 1'b1) begin
      e = qa.size() ? qa.pop_front() : 10'h3ff;
      chk("reply", e[8:0], {exp_err, exp_rdata});
    end
    if (io_in_valid === 1'b1)
      chk("io_in", {1'b0, qi.size() ? qi.pop_front() : 8'hff}, {1'b0, io_in_data});
  end
  initial begin
    tick(3000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {reset_msg, conn_timeout, bus_critical, poll_req, strobe_req} = '0;
    {cos_enable, pos_bottom, pos_top, send, valve} = '0;
    {exp_class, exp_attr, exp_wdata} = '0;
    rst = 1'b1;
    conn_open = 1'b1;
    exp_svc = FVS_SVC_NONE;
    exp_inst = INST_ONE;
    config_switch = $random(seed);
    tick(12);
    rst = 1'b0;
    sw = config_switch;
    tick(1);
    config_switch = ~sw;
    tick(2);
    chk("config", {1'b0, sw}, {1'b0, rate_code, node_address});
    for (int i = 0; i < 4; i++) begin
      chk("held", {1'b0, sw}, {1'b0, rate_code, node_address});
      sw = {i[1:0], (i == 1) ? 6'h3f : 6'($random(seed))};
      config_switch = sw;
      reset_msg = 1'b1;
      tick(1);
      reset_msg = 1'b0;
      config_switch = ~sw;
      tick(3);
      chk("rate", {sw, i == 3}, {rate_code, node_address, rate_bad});
    end
    $display("test config done");
    for (int i = 0; i < 4; i++) begin
      {pos_top, pos_bottom} = 2'($random(seed));
      tick(2);
      req(FVS_SVC_GET, CLS_PROCESS, ATT_PROCESS, 8'h00, {4'h8, 4'h0, pos_top, pos_bottom});
      qi.push_back({6'h00, pos_top, pos_bottom});
      poll_req = i[0];
      strobe_req = !i[0];
      tick(1);
      {poll_req, strobe_req} = '0;
      tick(2);
    end
    cos_enable = 1'b1;
    tick(1);
    qi.push_back({6'h00, pos_top, !pos_bottom});
    pos_bottom = !pos_bottom;
    tick(3);
    cos_enable = 1'b0;
    $display("test process done");
    write_valve(1'b1);
    chk("valve", 9'h001, {8'h00, pilot_valve_one});
    req(FVS_SVC_SET, CLS_PROCESS, ATT_PROCESS, 8'h00, 10'h000);
    chk("valve", 9'h000, {8'h00, pilot_valve_one});
    req(FVS_SVC_GET, CLS_CONFIG, ATT_FLT_MODE, 8'h00, 10'h200);
    req(FVS_SVC_GET, CLS_CONFIG, ATT_SAFE_VAL, 8'h00, 10'h200);
    req(FVS_SVC_SET, CLS_CONFIG, ATT_SAFE_VAL, 8'hff, 10'h000);
    req(FVS_SVC_GET, CLS_CONFIG, ATT_SAFE_VAL, 8'h00, 10'h201);
    req(FVS_SVC_GET, 8'h05, ATT_PROCESS, 8'h00, 10'h300);
    exp_inst = 8'h02;
    req(FVS_SVC_GET, CLS_PROCESS, ATT_PROCESS, 8'h00, 10'h100);
    exp_inst = INST_ONE;
    req(FVS_SVC_SET, CLS_CONFIG, 8'h08, 8'h01, 10'h100);
    chk("led", 9'h001, {7'h00, led_red, led_green});
    conn_open = 1'b0;
    tick(4);
    chk("safe", 9'h001, {8'h00, pilot_valve_one});
    chk("led", 9'h000, {7'h00, led_red, led_green});
    poll_req = 1'b1;
    tick(1);
    poll_req = 1'b0;
    tick(2);
    write_valve(1'b0);
    chk("safe", 9'h001, {8'h00, pilot_valve_one});
    req(FVS_SVC_SET, CLS_CONFIG, ATT_FLT_MODE, 8'h01, 10'h000);
    req(FVS_SVC_GET, CLS_CONFIG, ATT_FLT_MODE, 8'h00, 10'h201);
    chk("hold", 9'h000, {8'h00, pilot_valve_one});
    bus_critical = 1'b1;
    tick(3);
    chk("led", 9'h002, {7'h00, led_red, led_green});
    {conn_open, bus_critical} = 2'b10;
    write_valve(1'b1);
    conn_timeout = 1'b1;
    tick(2);
    chk("led", 9'h000, {7'h00, led_red, led_green});
    write_valve(1'b0);
    chk("hold", 9'h001, {8'h00, pilot_valve_one});
    conn_timeout = 1'b0;
    tick(2);
    $display("test fault done");
    report_and_stop();
  end
endmodule : fvs_slave_tb
